// [rtl/fault_pkg.sv]
package fault_pkg;

    // clock and timing
    localparam int CLK_HZ       = 100_000_000;
    localparam int CYC_PER_MS   = CLK_HZ / 1000;
    localparam int OT_HOLD_MS   = 10;
    localparam int WD_WAIT_MS   = 100;
    localparam int OT_HOLD_CYC  = OT_HOLD_MS * CYC_PER_MS;
    localparam int WD_WAIT_CYC  = WD_WAIT_MS * CYC_PER_MS;
    localparam int CNT_W        = 24;

    // register map, byte addresses
    localparam int         ADDR_W     = 8;
    localparam logic [7:0] ADDR_CTRL  = 8'h00;
    localparam logic [7:0] ADDR_DEMAND= 8'h04;
    localparam logic [7:0] ADDR_STATUS= 8'h08;
    localparam logic [7:0] ADDR_DIAG  = 8'h0c;
    localparam logic [7:0] ADDR_STATE = 8'h10;

    // control register fields
    localparam int         CTRL_W      = 4;
    localparam int         CTRL_RUN    = 0;
    localparam int         CTRL_ESF    = 1;
    localparam int         CTRL_RSC    = 2;
    localparam int         CTRL_RDHOLD = 3;
    localparam logic [3:0] CTRL_RESET  = 4'h2;

    // demand register
    localparam int         DEMAND_W     = 8;
    localparam logic [7:0] DEMAND_RESET = 8'h00;

    // status bit positions
    localparam int ST_W   = 8;
    localparam int ST_SYS = 0;
    localparam int ST_POR = 1;
    localparam int ST_MUV = 2;
    localparam int ST_GUV = 3;
    localparam int ST_LUV = 4;
    localparam int ST_WD  = 5;
    localparam int ST_OT  = 6;
    localparam int ST_LOS = 7;

    // diagnostic layout: shorts low, bootstrap above
    localparam int NFET   = 6;
    localparam int NPH    = 3;
    localparam int DG_W   = NFET + NPH;
    localparam int DG_BST = NFET;

    // live state register width
    localparam int SV_W = 10;

    // fault detector inputs
    typedef struct packed {
        logic            sys_err;
        logic            motor_por;
        logic            motor_uv;
        logic            gate_uv;
        logic            lr_uv;
        logic            wd_fault;
        logic            overtemp;
        logic            sync_loss;
        logic            wd_toggle;
        logic [NFET-1:0] short_flt;
        logic [NPH-1:0]  boot_uv;
    } fault_in_s;

    localparam int FIN_W = $bits(fault_in_s);

endpackage

// [rtl/sync3.sv]
`timescale 1ns/100ps
// three-stage pin synchroniser, output follows when stages two and three agree
module sync3
    import fault_pkg::*;
#(
    parameter int W = 1
)(
    // clock and reset
    input  wire logic         mclk,
    input  wire logic         rst,
    input  wire logic         ce,
    // data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;
    logic [W-1:0] q_nxt;

    // per bit: a high level needs stages two and three both high, a disagreement clears the bit
    assign q_nxt = (s2_r & s3_r) | (q & ~(s2_r ^ s3_r));

    // shift chain
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            q    <= '0;
        end
        else if (ce)
        begin
            s1_r <= d;
            s2_r <= s1_r;
            s3_r <= s2_r;
            q    <= q_nxt;
        end
    end

endmodule // sync3

// [rtl/fault_resp_ctrl.sv]
// Overview of operation
// - full shutdown drives all six gate outputs low
// - stop-on-fault plus motor-supply undervoltage: all gates off until it clears
// - undervoltage clears with auto-restart set: restart without host action
// - auto-restart clear: undervoltage state latched until demand, run, status read or reset
// - demand reset is demand to zero then a new nonzero value
// - run reset is run written zero then written one
// - stop-on-fault: short, bootstrap undervoltage or overtemperature turns all gates off
// - stop-on-fault: short/bootstrap state latched until demand, run, diag read or reset
// - stop-on-fault: overtemperature shutdown holds 10 ms after condition goes
// - stop-on-fault: overtemperature also stops logic regulator and asserts host reset
// - without stop-on-fault, overtemperature disables nothing
// - without stop-on-fault, short or bootstrap fault turns off only that MOSFET
// - that single-MOSFET disable holds until the phase's next PWM-on state
// - sync loss turns all gates off; with auto-restart, startup begins at once
// - auto-restart clear: sync loss latched until demand, run, status read or reset
// - logic regulator undervoltage or watchdog fault: gates off, host reset, latched
// - that state clears at first watchdog edge 100 ms after host reset release
// - serial clear needs read-hold zero and a status or diag read
// - diagnostic bits stay set until reset or read with read-hold zero
// - motor power-on reset or gate supply undervoltage forces gates off always
// - without stop-on-fault, motor-supply undervoltage only sets its flag
`timescale 1ns/100ps
module fault_resp_ctrl
    import fault_pkg::*;
#(
    parameter int OT_HOLD = OT_HOLD_CYC,
    parameter int WD_WAIT = WD_WAIT_CYC
)(
    // clock, reset, enable
    input  wire logic              mclk,
    input  wire logic              rst,
    input  wire logic              ce,
    // ahb-lite slave
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic      [31:0]       hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    // fault detectors, asynchronous pins
    input  wire fault_in_s         fault_pins,
    // commutation logic, same clock
    input  wire logic [NFET-1:0]   gate_cmd,
    input  wire logic [NPH-1:0]    pwm_on,
    // gate drive and system outputs
    output logic      [NFET-1:0]   gate_out,
    output logic                   restart_req,
    output logic                   host_reset_out_n,
    output logic                   logic_regulator_en
);

    fault_in_s           f;
    logic [CTRL_W-1:0]   ctrl_r;
    logic [DEMAND_W-1:0] demand_r;
    logic [ST_W-1:0]     status_r;
    logic [DG_W-1:0]     diag_r;
    logic                run_zero_r;
    logic                dem_zero_r;
    logic                mu_lat_r;
    logic                sb_lat_r;
    logic                ls_lat_r;
    logic                lw_lat_r;
    logic                se_lat_r;
    logic                ot_hold_r;
    logic [CNT_W-1:0]    ot_cnt_r;
    logic [CNT_W-1:0]    wd_cnt_r;
    logic                wd_prev_r;
    logic                muv_prev_r;
    logic [NFET-1:0]     fet_off_r;

    // synchronise all detector pins
    sync3 #(.W(FIN_W)) u_sync (
        .mclk (mclk),
        .rst  (rst),
        .ce   (ce),
        .d    (fault_pins),
        .q    (f)
    );

    // control fields
    wire run     = ctrl_r[CTRL_RUN];
    wire stop_on_fault_enable     = ctrl_r[CTRL_ESF];
    wire auto_restart_enable     = ctrl_r[CTRL_RSC];
    wire rd_hold = ctrl_r[CTRL_RDHOLD];

    // bus address phase decode
    wire         acc    = hsel & hready & htrans[1];
    wire [7:0]   a      = haddr[ADDR_W-1:0];
    wire         wr     = acc & hwrite;
    wire         rd     = acc & ~hwrite;
    wire         wr_ctl = wr & (a == ADDR_CTRL);
    wire         wr_dem = wr & (a == ADDR_DEMAND);
    wire         mapped = (a == ADDR_CTRL) | (a == ADDR_DEMAND) | (a == ADDR_STATUS)
                        | (a == ADDR_DIAG) | (a == ADDR_STATE);

    // write data is valid in the data phase after the address phase
    logic        wr_ctl_d_r;
    logic        wr_dem_d_r;
    wire         wd_run = hwdata[CTRL_RUN];
    wire [7:0]   wd_dem = hwdata[DEMAND_W-1:0];

    // read clears only with read-hold low, status or diag word
    wire st_rd = rd & ~rd_hold & (a == ADDR_STATUS);
    wire dg_rd = rd & ~rd_hold & (a == ADDR_DIAG);

    // demand and run reset events
    wire dem_rst  = wr_dem_d_r & dem_zero_r & (wd_dem != DEMAND_RESET);
    wire run_rst  = wr_ctl_d_r & run_zero_r & wd_run;
    wire host_clr = dem_rst | run_rst;
    wire por_now  = f.motor_por;

    // fault summaries
    wire any_short = |f.short_flt;
    wire any_boot  = |f.boot_uv;
    wire muv_fall  = muv_prev_r & ~f.motor_uv;
    wire lw_now    = f.lr_uv | f.wd_fault;
    wire ot_shut   = stop_on_fault_enable & (f.overtemp | ot_hold_r);
    wire wd_edge   = f.wd_toggle ^ wd_prev_r;
    wire wd_done   = (wd_cnt_r == CNT_W'(WD_WAIT));
    wire ot_done   = (ot_cnt_r == CNT_W'(OT_HOLD));

    // latch set and clear terms, set wins
    wire mu_set = stop_on_fault_enable & ~auto_restart_enable & f.motor_uv;
    wire mu_clr = host_clr | st_rd | por_now;
    wire sb_set = stop_on_fault_enable & (any_short | any_boot);
    wire sb_clr = host_clr | dg_rd | por_now;
    wire ls_set = ~auto_restart_enable & f.sync_loss;
    wire ls_clr = host_clr | st_rd | por_now;
    wire lw_clr = host_reset_out_n & wd_done & wd_edge;
    wire se_clr = (wr_ctl_d_r & wd_run) | por_now;

    // everything that turns every gate off
    wire all_off = por_now | f.gate_uv
                 | (stop_on_fault_enable & f.motor_uv) | mu_lat_r
                 | (stop_on_fault_enable & (any_short | any_boot)) | sb_lat_r
                 | ot_shut
                 | f.sync_loss | ls_lat_r
                 | lw_now | lw_lat_r
                 | f.sys_err | se_lat_r
                 | ~run;

    // per-fet faults without stop-on-fault: bootstrap hits the phase high side
    logic [NFET-1:0] fet_flt;
    logic [NFET-1:0] fet_pwm;
    always_comb
    begin
        for (int i = 0; i < NFET; i++)
        begin
            fet_flt[i] = f.short_flt[i] | (((i % 2) == 0) & f.boot_uv[i/2]);
            fet_pwm[i] = pwm_on[i/2];
        end
    end
    wire [NFET-1:0] fet_set = {NFET{~stop_on_fault_enable}} & fet_flt;
    wire [NFET-1:0] fet_off_nxt = fet_set | (fet_off_r & ~fet_pwm);

    // gate drive after all disables
    wire [NFET-1:0] gate_nxt = all_off ? '0 : (gate_cmd & ~fet_off_nxt);

    // restart request: undervoltage gone with auto-restart, or sync loss with it
    wire rst_req_nxt = stop_on_fault_enable & auto_restart_enable & muv_fall & run
                     | auto_restart_enable & f.sync_loss & run;

    // host reset holds while regulator or watchdog fault or overtemperature; logic regulator stops on overtemperature only
    wire hrst_n_nxt = ~(lw_now | ot_shut);

    // sticky status, set wins over read clear
    logic [ST_W-1:0] st_set;
    always_comb
    begin
        st_set         = '0;
        st_set[ST_SYS] = f.sys_err;
        st_set[ST_POR] = f.motor_por;
        st_set[ST_MUV] = f.motor_uv;
        st_set[ST_GUV] = f.gate_uv;
        st_set[ST_LUV] = f.lr_uv;
        st_set[ST_WD]  = f.wd_fault;
        st_set[ST_OT]  = f.overtemp;
        st_set[ST_LOS] = f.sync_loss;
    end
    wire [ST_W-1:0] status_nxt = st_set | (st_rd ? '0 : status_r);
    wire [DG_W-1:0] diag_set   = {f.boot_uv, f.short_flt};
    wire [DG_W-1:0] diag_nxt   = diag_set | (dg_rd ? '0 : diag_r);

    // live state word
    wire [SV_W-1:0] state_v = {logic_regulator_en, host_reset_out_n, ot_hold_r, lw_lat_r,
                               ls_lat_r, sb_lat_r, mu_lat_r, se_lat_r, all_off, run};

    // read mux
    logic [31:0] rd_mux;
    always_comb
    begin
        rd_mux = '0;
        unique case (1'b1)
            (a == ADDR_CTRL):   rd_mux[CTRL_W-1:0]   = ctrl_r;
            (a == ADDR_DEMAND): rd_mux[DEMAND_W-1:0] = demand_r;
            (a == ADDR_STATUS): rd_mux[ST_W-1:0]     = status_r;
            (a == ADDR_DIAG):   rd_mux[DG_W-1:0]     = diag_r;
            (a == ADDR_STATE):  rd_mux[SV_W-1:0]     = state_v;
            default:            rd_mux               = '0;
        endcase
    end

    // control register next value, system error forces run low
    logic [CTRL_W-1:0] ctrl_nxt;
    always_comb
    begin
        ctrl_nxt = wr_ctl_d_r ? hwdata[CTRL_W-1:0] : ctrl_r;
        if (f.sys_err)
        begin
            ctrl_nxt[CTRL_RUN] = 1'b0;
        end
    end

    // bus slave registers
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            wr_ctl_d_r <= 1'b0;
            wr_dem_d_r <= 1'b0;
            hrdata     <= '0;
            hreadyout  <= 1'b1;
            hresp      <= 1'b0;
        end
        else if (ce)
        begin
            wr_ctl_d_r <= wr_ctl;
            wr_dem_d_r <= wr_dem;
            hrdata     <= (rd & mapped) ? rd_mux : '0;
        end
    end

    // software-visible control and sticky flags
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            ctrl_r   <= CTRL_RESET;
            demand_r <= DEMAND_RESET;
            status_r <= '0;
            diag_r   <= '0;
        end
        else if (ce)
        begin
            ctrl_r   <= ctrl_nxt;
            demand_r <= wr_dem_d_r ? wd_dem : demand_r;
            status_r <= status_nxt;
            diag_r   <= diag_nxt;
        end
    end

    // demand and run zero trackers
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            run_zero_r <= 1'b0;
            dem_zero_r <= 1'b0;
        end
        else if (ce)
        begin
            if (wr_ctl_d_r)
                run_zero_r <= ~wd_run;
            if (wr_dem_d_r)
                dem_zero_r <= (wd_dem == DEMAND_RESET);
        end
    end

    // latched fault states, set wins over clear
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            mu_lat_r <= 1'b0;
            sb_lat_r <= 1'b0;
            ls_lat_r <= 1'b0;
            lw_lat_r <= 1'b0;
            se_lat_r <= 1'b0;
        end
        else if (ce)
        begin
            mu_lat_r <= mu_set | (mu_lat_r & ~mu_clr);
            sb_lat_r <= sb_set | (sb_lat_r & ~sb_clr);
            ls_lat_r <= ls_set | (ls_lat_r & ~ls_clr);
            lw_lat_r <= lw_now | (lw_lat_r & ~lw_clr);
            se_lat_r <= f.sys_err | (se_lat_r & ~se_clr);
        end
    end

    // overtemperature hold timer runs after the condition goes
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            ot_hold_r <= 1'b0;
            ot_cnt_r  <= '0;
        end
        else if (ce)
        begin
            if (stop_on_fault_enable & f.overtemp)
            begin
                ot_hold_r <= 1'b1;
                ot_cnt_r  <= '0;
            end
            else if (ot_hold_r & ot_done)
            begin
                ot_hold_r <= 1'b0;
            end
            else if (ot_hold_r)
            begin
                ot_cnt_r <= ot_cnt_r + CNT_W'(1);
            end
        end
    end

    // watchdog wait counter from host reset release
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            wd_cnt_r  <= '0;
            wd_prev_r <= 1'b0;
        end
        else if (ce)
        begin
            wd_prev_r <= f.wd_toggle;
            if (~host_reset_out_n)
                wd_cnt_r <= '0;
            else if (~wd_done)
                wd_cnt_r <= wd_cnt_r + CNT_W'(1);
        end
    end

    // gate, restart and host outputs
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            fet_off_r          <= '0;
            muv_prev_r         <= 1'b0;
            gate_out           <= '0;
            restart_req        <= 1'b0;
            host_reset_out_n   <= 1'b0;
            logic_regulator_en <= 1'b0;
        end
        else if (ce)
        begin
            fet_off_r          <= fet_off_nxt;
            muv_prev_r         <= f.motor_uv;
            gate_out           <= gate_nxt;
            restart_req        <= rst_req_nxt;
            host_reset_out_n   <= hrst_n_nxt;
            logic_regulator_en <= ~ot_shut;
        end
    end

endmodule // fault_resp_ctrl

// [test/fault_resp_monitor.sv]
`timescale 1ns/100ps
// port checker for the fault response controller
module fault_resp_monitor
    import fault_pkg::*;
#(
    parameter int OT_HOLD = OT_HOLD_CYC,
    parameter int WD_WAIT = WD_WAIT_CYC
)(
    // clock and reset
    input  wire logic            mclk,
    input  wire logic            rst,
    // register bus
    input  wire logic            hsel,
    input  wire logic [1:0]      htrans,
    input  wire logic            hwrite,
    input  wire logic            hready,
    input  wire logic [31:0]     hrdata,
    input  wire logic            hreadyout,
    input  wire logic            hresp,
    // faults and drive outputs
    input  wire fault_in_s       fault_pins,
    input  wire logic [NFET-1:0] gate_out,
    input  wire logic            host_reset_out_n,
    input  wire logic            logic_regulator_en
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    // pins held well past synchroniser latency
    chk_por_gates_off: assert property (fault_pins.motor_por [*7] |-> gate_out == '0)
        else $error("gates on during motor power-on reset");
    chk_guv_gates_off: assert property (fault_pins.gate_uv [*7] |-> gate_out == '0)
        else $error("gates on during gate supply undervoltage");
    chk_lruv_host_rst: assert property (fault_pins.lr_uv [*7] |-> gate_out == '0 && !host_reset_out_n)
        else $error("regulator undervoltage without shutdown and host reset");
    chk_sys_gates_off: assert property (fault_pins.sys_err [*7] |-> gate_out == '0)
        else $error("gates on during system error");
    chk_sync_gates_off: assert property (fault_pins.sync_loss [*7] |-> gate_out == '0)
        else $error("gates on during sync loss");
    // regulator only stops together with host reset
    chk_reg_with_reset: assert property (!logic_regulator_en |-> !host_reset_out_n)
        else $error("regulator off without host reset");
    chk_reset_gates_off: assert property (!host_reset_out_n && $past(!host_reset_out_n) |-> gate_out == '0)
        else $error("gates on while host held in reset");
    // bus answers at once and read data only in a read data phase
    chk_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus wait state or error response");
    chk_rdata_phase: assert property (hrdata != '0 |-> $past(hsel && hready && htrans[1] && !hwrite))
        else $error("read data outside a read data phase");
endmodule // fault_resp_monitor

// [test/host_mcu_model.sv]
`timescale 1ns/100ps
// host controller: kicks the watchdog while released from reset
module host_mcu_model #(
    parameter int KICK = 16
)(
    // clock and reset
    input  wire logic mclk,
    input  wire logic rst,
    // reset line from the device
    input  wire logic host_reset_out_n,
    // watchdog kick
    output logic      wd_toggle
);
    int cnt;

    // kick frozen while host is held in reset
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            cnt <= 0;
            wd_toggle <= 1'b0;
        end
        else if (!host_reset_out_n)
            cnt <= 0;
        else if (cnt == KICK - 1)
        begin
            cnt <= 0;
            wd_toggle <= ~wd_toggle;
        end
        else
            cnt <= cnt + 1;
    end
endmodule // host_mcu_model

// [test/tb.sv]
`timescale 1ns/100ps
module tb
    import fault_pkg::*;
;
    localparam int OTH = 20;
    localparam int WDW = 50;
    logic            mclk = 1'b0;
    logic            rst = 1'b1;
    logic            ce = 1'b1;
    logic            hsel = 1'b0;
    logic            hwrite = 1'b0;
    logic [1:0]      htrans = 2'b00;
    logic [2:0]      hsize = 3'b010;
    logic [31:0]     haddr = 32'h0;
    logic [31:0]     hwdata = 32'h0;
    logic [NFET-1:0] gate_cmd = 6'h3f;
    logic [NPH-1:0]  pwm_on = 3'h0;
    fault_in_s       fs = '0;
    fault_in_s       fin;
    logic            wd_tog;
    logic            hready;
    logic [31:0]     hrdata;
    logic            hreadyout;
    logic            hresp;
    logic [NFET-1:0] gate_out;
    logic            restart_req;
    logic            host_reset_out_n;
    logic            logic_regulator_en;
    logic [31:0]     rd;
    int              n_errors = 0;
    int              n_compared = 0;
    int              n_restart = 0;
    int              k0;
    int              cyc = 0;

    always #5 mclk = ~mclk;
    assign hready = hreadyout;
    // watchdog kick comes from the host model
    always_comb
    begin
        fin = fs;
        fin.wd_toggle = wd_tog;
    end

    fault_resp_ctrl #(.OT_HOLD(OTH), .WD_WAIT(WDW)) dut (
        .mclk(mclk), .rst(rst), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .fault_pins(fin), .gate_cmd(gate_cmd),
        .pwm_on(pwm_on), .gate_out(gate_out), .restart_req(restart_req),
        .host_reset_out_n(host_reset_out_n), .logic_regulator_en(logic_regulator_en));

    host_mcu_model u_host (.mclk(mclk), .rst(rst), .host_reset_out_n(host_reset_out_n), .wd_toggle(wd_tog));

    // restart request high-cycle count and hang guard
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (restart_req === 1'b1)
            n_restart <= n_restart + 1;
        if (cyc == 6000)
        begin
            n_errors = n_errors + 1;
            stop_test();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= wr;
        htrans <= 2'b10;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic w(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic r(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(rd, e);
    endtask

    task automatic g(input logic [NFET-1:0] e);
        repeat (8) @(posedge mclk);
        chk(32'(gate_out), 32'(e));
    endtask

    task automatic on(input fault_in_s m);
        @(posedge mclk);
        fs <= m;
    endtask

    task automatic pulse(input fault_in_s m);
        on(m);
        repeat (8) @(posedge mclk);
        fs <= '0;
    endtask

    task automatic done(input int n);
        $display("test %0d finished", n);
    endtask

    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial
    begin
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        // reset values, unmapped place, read-only write
        r(ADDR_CTRL, 32'h2);
        r(8'h1c, 32'h0);
        w(ADDR_STATUS, 32'hff);
        r(ADDR_STATUS, 32'h0);
        w(ADDR_DEMAND, 32'h40);
        g(6'h00);
        w(ADDR_CTRL, 32'h3);
        g(6'h3f);
        gate_cmd <= 6'h15;
        g(6'h15);
        gate_cmd <= 6'h3f;
        done(1);
        // short fault latch and diagnostic read with and without hold
        pulse('{short_flt: 6'h04, default: '0});
        g(6'h00);
        w(ADDR_CTRL, 32'hb);
        r(ADDR_DIAG, 32'h004);
        g(6'h00);
        w(ADDR_CTRL, 32'h3);
        r(ADDR_DIAG, 32'h004);
        r(ADDR_DIAG, 32'h000);
        g(6'h3f);
        done(2);
        // bootstrap fault cleared by demand reset
        pulse('{boot_uv: 3'h2, default: '0});
        g(6'h00);
        w(ADDR_DEMAND, 32'h40);
        g(6'h00);
        w(ADDR_DEMAND, 32'h0);
        g(6'h00);
        w(ADDR_DEMAND, 32'h80);
        g(6'h3f);
        r(ADDR_DEMAND, 32'h80);
        r(ADDR_DIAG, 32'h080);
        done(3);
        // sync loss latch cleared by run reset
        pulse('{sync_loss: 1'b1, default: '0});
        g(6'h00);
        w(ADDR_CTRL, 32'h3);
        g(6'h00);
        w(ADDR_CTRL, 32'h2);
        w(ADDR_CTRL, 32'h3);
        g(6'h3f);
        r(ADDR_STATUS, 32'h80);
        done(4);
        // motor supply undervoltage, no auto restart
        on('{motor_uv: 1'b1, default: '0});
        g(6'h00);
        on('0);
        g(6'h00);
        r(ADDR_STATUS, 32'h04);
        g(6'h3f);
        done(5);
        // auto restart after undervoltage and sync loss
        w(ADDR_CTRL, 32'h7);
        k0 = n_restart;
        on('{motor_uv: 1'b1, default: '0});
        g(6'h00);
        on('0);
        g(6'h3f);
        chk(32'(n_restart != k0), 32'h1);
        k0 = n_restart;
        on('{sync_loss: 1'b1, default: '0});
        g(6'h00);
        chk(32'(n_restart != k0), 32'h1);
        on('0);
        g(6'h3f);
        r(ADDR_STATUS, 32'h84);
        done(6);
        // stop-on-fault off: flags only, single transistor off
        w(ADDR_CTRL, 32'h1);
        on('{motor_uv: 1'b1, overtemp: 1'b1, default: '0});
        g(6'h3f);
        chk(32'(host_reset_out_n), 32'h1);
        on('{short_flt: 6'h10, default: '0});
        g(6'h2f);
        on('0);
        g(6'h2f);
        pwm_on <= 3'h4;
        g(6'h3f);
        pwm_on <= 3'h0;
        r(ADDR_STATUS, 32'h44);
        r(ADDR_DIAG, 32'h010);
        done(7);
        // overtemperature shutdown and hold time
        w(ADDR_CTRL, 32'h3);
        pulse('{overtemp: 1'b1, default: '0});
        repeat (12) @(posedge mclk);
        chk({29'h0, host_reset_out_n, logic_regulator_en, |gate_out}, 32'h0);
        repeat (OTH + 10) @(posedge mclk);
        chk({30'h0, host_reset_out_n, logic_regulator_en}, 32'h3);
        done(8);
        // regulator undervoltage, cleared by watchdog after wait
        pulse('{lr_uv: 1'b1, default: '0});
        chk({30'h0, host_reset_out_n, |gate_out}, 32'h0);
        pulse('{wd_fault: 1'b1, default: '0});
        chk({30'h0, host_reset_out_n, |gate_out}, 32'h0);
        repeat (30) @(posedge mclk);
        xfer(1'b0, ADDR_STATE, 32'h0);
        chk(rd & 32'h40, 32'h40);
        repeat (WDW + 40) @(posedge mclk);
        xfer(1'b0, ADDR_STATE, 32'h0);
        chk(rd & 32'h40, 32'h0);
        r(ADDR_STATUS, 32'h70);
        w(ADDR_CTRL, 32'h2);
        w(ADDR_CTRL, 32'h3);
        g(6'h3f);
        done(9);
        // system error forces run low
        pulse('{sys_err: 1'b1, default: '0});
        g(6'h00);
        r(ADDR_CTRL, 32'h2);
        w(ADDR_CTRL, 32'h3);
        g(6'h3f);
        done(10);
        // critical supply faults regardless of stop-on-fault
        w(ADDR_CTRL, 32'h1);
        on('{gate_uv: 1'b1, default: '0});
        g(6'h00);
        on('0);
        g(6'h3f);
        on('{motor_por: 1'b1, default: '0});
        g(6'h00);
        on('0);
        g(6'h3f);
        r(ADDR_STATUS, 32'h0b);
        done(11);
        // clock enable low: pins and state frozen
        @(posedge mclk);
        ce <= 1'b0;
        pulse('{short_flt: 6'h01, default: '0});
        g(6'h3f);
        @(posedge mclk);
        ce <= 1'b1;
        g(6'h3f);
        r(ADDR_DIAG, 32'h000);
        done(12);
        stop_test();
    end
endmodule // tb

bind fault_resp_ctrl fault_resp_monitor #(.OT_HOLD(OT_HOLD), .WD_WAIT(WD_WAIT)) u_mon (
    .mclk(mclk), .rst(rst), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .fault_pins(fault_pins),
    .gate_out(gate_out), .host_reset_out_n(host_reset_out_n), .logic_regulator_en(logic_regulator_en));
